// File: pkg/lpms_pkg.sv
package lpms_pkg;

   // Register byte offsets on the Wishbone slave.
   localparam logic [7:0] LPMS_ADDR_MODE     = 8'h00;
   localparam logic [7:0] LPMS_ADDR_CLKSRC   = 8'h04;
   localparam logic [7:0] LPMS_ADDR_USBPLL   = 8'h08;
   localparam logic [7:0] LPMS_ADDR_PCLKEN   = 8'h0c;
   localparam logic [7:0] LPMS_ADDR_PCLKDIV  = 8'h10;
   localparam logic [7:0] LPMS_ADDR_CPUDIV   = 8'h14;
   localparam logic [7:0] LPMS_ADDR_STATUS   = 8'h18;
   localparam logic [7:0] LPMS_ADDR_WAKEMASK = 8'h1c;

   localparam int LPMS_NPERIPH = 8;
   localparam int LPMS_NIRQ    = 32;

   // Mode selection encodings.
   localparam logic [1:0] LPMS_MODE_SLEEP = 2'h0;
   localparam logic [1:0] LPMS_MODE_DEEP  = 2'h1;
   localparam logic [1:0] LPMS_MODE_PDOWN = 2'h2;

   // Clock source encodings.
   localparam logic [1:0] LPMS_SRC_RC   = 2'h0;
   localparam logic [1:0] LPMS_SRC_MAIN = 2'h1;
   localparam logic [1:0] LPMS_SRC_PLL  = 2'h2;

   // USB PLL control field positions.
   localparam int LPMS_USB_EN_BIT  = 0;
   localparam int LPMS_USB_CON_BIT = 1;

   // Reset values.
   localparam logic [31:0] LPMS_PCLKEN_RST  = 32'h0000_00ff;
   localparam logic [31:0] LPMS_PCLKDIV_RST = 32'h0000_0000;
   localparam logic [7:0]  LPMS_CPUDIV_RST  = 8'h00;

   // Timing figures.
   localparam int LPMS_CLK_MHZ        = 125;
   localparam int LPMS_RC_MHZ         = 4;
   localparam int LPMS_RC_START_US    = 60;
   localparam int LPMS_FLASH_START_US = 100;
   localparam int LPMS_RC_WAKE_CYC    = 4;
   localparam int LPMS_MAIN_WAKE_CYC  = 4096;
   // Ratio of system clock to one RC cycle, rounded up.
   localparam int LPMS_RC_RATIO       = (LPMS_CLK_MHZ + LPMS_RC_MHZ - 1) / LPMS_RC_MHZ;
   localparam int LPMS_RC_START_CYC   = LPMS_RC_START_US * LPMS_CLK_MHZ;
   localparam int LPMS_FLASH_RC_CYC   = LPMS_FLASH_START_US * LPMS_RC_MHZ;

   typedef enum logic [2:0] {
      LPMS_RUN,
      LPMS_SLEEP,
      LPMS_DEEP,
      LPMS_PDOWN,
      LPMS_RCSTART,
      LPMS_WAKECNT,
      LPMS_DPD
   } lpms_state_t;

endpackage

// File: rtl/lpms_sequencer.sv
`timescale 1ns/1ps
// How it works
// - After reset the USB PLL is off; USB clock comes from main PLL 48 MHz.
// - USB PLL uses main oscillator only, 10-25 MHz in, 48 MHz 50% out.
// - Power-up and power-down wake run from the 4 MHz RC oscillator.
// - Every wake from power-down passes through the wake-up timer.
// - Sleep stops only the core clock; wake re-enables it.
// - Sleep holds execution until reset or interrupt; peripherals keep running.
// - Deep-sleep stops main oscillator and all clocks, retains state, holds pins.
// - Deep-sleep gates RC output but keeps it powered; RTC oscillator runs.
// - Deep-sleep turns off and disconnects the PLL, zeroes CPU and USB dividers.
// - Deep-sleep ends only on reset, clockless interrupt or RTC alarm; flash stays powered.
// - Deep-sleep wake waits 4 cycles from RC or 4096 from main oscillator.
// - Power-down also removes RC oscillator and flash power.
// - Flash wake counter counts RC cycles for 100 us; flash blocked until done.
// - Deep power-down entered only from the RTC; all but RTC and reset off.
// - Deep power-down ends only on reset pin or RTC alarm match.
// - Interrupt controller passes the enabled, serviceable interrupt mask.
// - Wake controller wakes on any masked interrupt without needing a clock.
// - Software can gate each peripheral clock individually.
// - Each peripheral has its own clock divider, separate from the CPU divider.
module lpms_sequencer
   import lpms_pkg::*;
(
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic [7:0]                 wb_adr_i,
   input  wire logic [31:0]                wb_dat_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic                       wb_we_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic                       sleep_req_i,
   input  wire logic [LPMS_NIRQ-1:0]       irq_mask_i,
   input  wire logic [LPMS_NIRQ-1:0]       irq_i,
   input  wire logic                       rtc_dpd_req_i,
   input  wire logic                       rtc_alarm_i,
   input  wire logic                       rc_tick_i,
   output logic                            cpu_clock_en_o,
   output logic                            periph_clock_en_o,
   output logic [LPMS_NPERIPH-1:0]         periph_gate_o,
   output logic [LPMS_NPERIPH*4-1:0]       periph_div_o,
   output logic [7:0]                      cpu_div_o,
   output logic [1:0]                      clk_src_o,
   output logic                            main_osc_en_o,
   output logic                            main_pll_en_o,
   output logic                            main_pll_connect_o,
   output logic                            internal_rc_osc_pwr_o,
   output logic                            internal_rc_osc_out_en_o,
   output logic                            usb_pll_pwr_o,
   output logic                            usb_pll_connect_o,
   output logic                            usb_div_zero_o,
   output logic                            flash_pwr_o,
   output logic                            flash_ready_o,
   output logic                            pin_hold_o,
   output logic                            chip_pwr_off_o,
   output logic                            wake_o
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      lpms_state_t                 st;
      logic [1:0]                  mode;
      logic [1:0]                  src;
      logic [1:0]                  src_at_sleep;
      logic [1:0]                  usb;
      logic [LPMS_NPERIPH-1:0]     pclken;
      logic [LPMS_NPERIPH*4-1:0]   pclkdiv;
      logic [7:0]                  cpudiv;
      logic [LPMS_NIRQ-1:0]        wmask;
      logic [15:0]                 cnt;
      logic [15:0]                 fcnt;
      logic                        fbusy;
      logic                        ack;
      logic [31:0]                 rdat;
   } lpms_s_t;

   lpms_s_t s_reg;
   lpms_s_t s_next;

   logic        wb_req;
   logic        irq_hit;
   logic [31:0] wdat;

   // The wake match is purely combinational, so it needs no clock edge to see an interrupt.
   assign irq_hit = |(irq_i & s_reg.wmask);
   assign wb_req  = wb_cyc_i && wb_stb_i && !s_reg.ack;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      s_next.ack = wb_req;
      wdat = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         wdat[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : 8'h00;
      end
      // Register writes.
      if (wb_req && wb_we_i) begin
         case (wb_adr_i)
            LPMS_ADDR_MODE: begin
               if (wb_sel_i[0] && wdat[1:0] != 2'h3) begin
                  s_next.mode = wdat[1:0];
               end
            end
            LPMS_ADDR_CLKSRC: begin
               // Selection is trusted; software must have stabilised the source first.
               if (wb_sel_i[0] && wdat[1:0] != 2'h3) begin
                  s_next.src = wdat[1:0];
               end
            end
            LPMS_ADDR_USBPLL: begin
               if (wb_sel_i[0]) begin
                  s_next.usb = wdat[1:0];
               end
            end
            LPMS_ADDR_PCLKEN: begin
               if (wb_sel_i[0]) begin
                  s_next.pclken = wdat[LPMS_NPERIPH-1:0];
               end
            end
            LPMS_ADDR_PCLKDIV: begin
               for (int b = 0; b < 4; b++) begin
                  if (wb_sel_i[b]) begin
                     s_next.pclkdiv[b*8 +: 8] = wdat[b*8 +: 8];
                  end
               end
            end
            LPMS_ADDR_CPUDIV: begin
               if (wb_sel_i[0]) begin
                  s_next.cpudiv = wdat[7:0];
               end
            end
            default: begin
            end
         endcase
      end
      // Register reads; unmapped addresses read zero but still acknowledge.
      s_next.rdat = 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            LPMS_ADDR_MODE:     s_next.rdat = {30'h0, s_reg.mode};
            LPMS_ADDR_CLKSRC:   s_next.rdat = {30'h0, s_reg.src};
            LPMS_ADDR_USBPLL:   s_next.rdat = {30'h0, s_reg.usb};
            LPMS_ADDR_PCLKEN:   s_next.rdat = {24'h0, s_reg.pclken};
            LPMS_ADDR_PCLKDIV:  s_next.rdat = s_reg.pclkdiv;
            LPMS_ADDR_CPUDIV:   s_next.rdat = {24'h0, s_reg.cpudiv};
            LPMS_ADDR_STATUS:   s_next.rdat = {27'h0, s_reg.fbusy, 1'b0, s_reg.st};
            LPMS_ADDR_WAKEMASK: s_next.rdat = s_reg.wmask;
            default:            s_next.rdat = 32'h0000_0000;
         endcase
      end
      // Flash wake counter runs on RC ticks once flash has power again.
      if (s_reg.fbusy && s_reg.st != LPMS_PDOWN && rc_tick_i) begin
         if (s_reg.fcnt == 16'(LPMS_FLASH_RC_CYC - 1)) begin
            s_next.fbusy = 1'b0;
         end else begin
            s_next.fcnt = s_reg.fcnt + 16'h0001;
         end
      end
      // Power-mode sequencer.
      case (s_reg.st)
         LPMS_RUN: begin
            if (rtc_dpd_req_i) begin
               s_next.st = LPMS_DPD;
            end else if (sleep_req_i) begin
               s_next.wmask = irq_mask_i;
               s_next.src_at_sleep = s_reg.src;
               case (s_reg.mode)
                  LPMS_MODE_DEEP: begin
                     s_next.st = LPMS_DEEP;
                  end
                  LPMS_MODE_PDOWN: begin
                     s_next.st = LPMS_PDOWN;
                     s_next.fbusy = 1'b1;
                  end
                  default: begin
                     s_next.st = LPMS_SLEEP;
                  end
               endcase
               if (s_reg.mode != LPMS_MODE_SLEEP) begin
                  // Entering a stopped-clock mode drops the PLLs and the CPU divider.
                  s_next.usb    = 2'h0;
                  s_next.cpudiv = 8'h00;
                  s_next.src    = LPMS_SRC_RC;
               end
            end
         end
         LPMS_SLEEP: begin
            // Any enabled interrupt resumes the core; mask was latched at entry.
            if (irq_hit) begin
               s_next.st = LPMS_RUN;
            end
         end
         LPMS_DEEP: begin
            if (irq_hit || rtc_alarm_i) begin
               s_next.st  = LPMS_WAKECNT;
               s_next.cnt = 16'h0000;
            end
         end
         LPMS_PDOWN: begin
            if (irq_hit || rtc_alarm_i) begin
               s_next.st  = LPMS_RCSTART;
               s_next.cnt = 16'h0000;
               s_next.fcnt = 16'h0000;
            end
         end
         LPMS_RCSTART: begin
            if (s_reg.cnt == 16'(LPMS_RC_START_CYC - 1)) begin
               s_next.st  = LPMS_WAKECNT;
               s_next.cnt = 16'h0000;
               s_next.src_at_sleep = LPMS_SRC_RC;
            end else begin
               s_next.cnt = s_reg.cnt + 16'h0001;
            end
         end
         LPMS_WAKECNT: begin
            // Counts system cycles: 4 RC cycles' worth when waking on RC, 4096 otherwise.
            if ((s_reg.src_at_sleep == LPMS_SRC_RC &&
                 s_reg.cnt == 16'(LPMS_RC_WAKE_CYC * LPMS_RC_RATIO - 1)) ||
                (s_reg.src_at_sleep != LPMS_SRC_RC &&
                 s_reg.cnt == 16'(LPMS_MAIN_WAKE_CYC - 1))) begin
               s_next.st = LPMS_RUN;
            end else begin
               s_next.cnt = s_reg.cnt + 16'h0001;
            end
         end
         LPMS_DPD: begin
            // Only the alarm or a chip reset leaves this state.
            if (rtc_alarm_i) begin
               s_next.st = LPMS_RUN;
            end
         end
         default: begin
            s_next.st = LPMS_RUN;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg         <= '0;
         s_reg.st      <= LPMS_RUN;
         s_reg.mode    <= LPMS_MODE_SLEEP;
         s_reg.src     <= LPMS_SRC_RC;
         s_reg.usb     <= 2'h0;
         s_reg.pclken  <= LPMS_PCLKEN_RST[LPMS_NPERIPH-1:0];
         s_reg.pclkdiv <= LPMS_PCLKDIV_RST;
         s_reg.cpudiv  <= LPMS_CPUDIV_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs are decoded from the next state and registered.
   logic stop_n;
   logic pd_n;
   assign stop_n = s_next.st == LPMS_RUN || s_next.st == LPMS_SLEEP;
   // The RC oscillator must have power again while its own start-up time runs.
   assign pd_n   = !(s_next.st == LPMS_PDOWN || s_next.st == LPMS_DPD);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o                 <= 32'h0000_0000;
         wb_ack_o                 <= 1'b0;
         cpu_clock_en_o           <= 1'b1;
         periph_clock_en_o        <= 1'b1;
         periph_gate_o            <= LPMS_PCLKEN_RST[LPMS_NPERIPH-1:0];
         periph_div_o             <= LPMS_PCLKDIV_RST;
         cpu_div_o                <= LPMS_CPUDIV_RST;
         clk_src_o                <= LPMS_SRC_RC;
         main_osc_en_o            <= 1'b0;
         main_pll_en_o            <= 1'b0;
         main_pll_connect_o       <= 1'b0;
         internal_rc_osc_pwr_o    <= 1'b1;
         internal_rc_osc_out_en_o <= 1'b1;
         usb_pll_pwr_o            <= 1'b0;
         usb_pll_connect_o        <= 1'b0;
         usb_div_zero_o           <= 1'b0;
         flash_pwr_o              <= 1'b1;
         flash_ready_o            <= 1'b1;
         pin_hold_o               <= 1'b0;
         chip_pwr_off_o           <= 1'b0;
         wake_o                   <= 1'b0;
      end else begin
         wb_dat_o                 <= s_next.rdat;
         wb_ack_o                 <= s_next.ack;
         cpu_clock_en_o           <= s_next.st == LPMS_RUN;
         periph_clock_en_o        <= stop_n;
         periph_gate_o            <= stop_n ? s_next.pclken : '0;
         periph_div_o             <= s_next.pclkdiv;
         cpu_div_o                <= s_next.cpudiv;
         clk_src_o                <= s_next.src;
         main_osc_en_o            <= stop_n && s_next.src != LPMS_SRC_RC;
         main_pll_en_o            <= stop_n && s_next.src == LPMS_SRC_PLL;
         main_pll_connect_o       <= stop_n && s_next.src == LPMS_SRC_PLL;
         internal_rc_osc_pwr_o    <= pd_n;
         internal_rc_osc_out_en_o <= stop_n;
         // The USB PLL runs from the main oscillator, so it needs that oscillator up.
         usb_pll_pwr_o            <= stop_n && s_next.usb[LPMS_USB_EN_BIT] &&
                                     s_next.src != LPMS_SRC_RC;
         usb_pll_connect_o        <= stop_n && s_next.usb[LPMS_USB_EN_BIT] &&
                                     s_next.usb[LPMS_USB_CON_BIT] &&
                                     s_next.src != LPMS_SRC_RC;
         usb_div_zero_o           <= !stop_n;
         flash_pwr_o              <= pd_n || s_next.st == LPMS_RCSTART ?
                                     s_next.st != LPMS_DPD && s_next.st != LPMS_PDOWN : 1'b0;
         flash_ready_o            <= !s_next.fbusy;
         pin_hold_o               <= !stop_n;
         chip_pwr_off_o           <= s_next.st == LPMS_DPD;
         wake_o                   <= s_next.st == LPMS_RUN && s_reg.st != LPMS_RUN;
      end
   end

endmodule

// File: bench/lpms_props.sv
`timescale 1ns/1ps
module lpms_props
   import lpms_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    sleep_req_i,
   input  wire logic                    rtc_dpd_req_i,
   input  wire logic                    rtc_alarm_i,
   input  wire logic [LPMS_NIRQ-1:0]    irq_i,
   input  wire logic [LPMS_NIRQ-1:0]    irq_mask_i,
   input  wire logic                    cpu_clock_en_o,
   input  wire logic                    periph_clock_en_o,
   input  wire logic [LPMS_NPERIPH-1:0] periph_gate_o,
   input  wire logic                    usb_div_zero_o,
   input  wire logic                    usb_pll_pwr_o,
   input  wire logic                    usb_pll_connect_o,
   input  wire logic                    internal_rc_osc_pwr_o,
   input  wire logic                    internal_rc_osc_out_en_o,
   input  wire logic                    flash_pwr_o,
   input  wire logic                    flash_ready_o,
   input  wire logic                    pin_hold_o,
   input  wire logic                    chip_pwr_off_o,
   input  wire logic                    wake_o
);
   default clocking dclk @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////
   usb_reset_a: assert property ($fell(rst_i) |-> !usb_pll_pwr_o && !usb_pll_connect_o)
      else $error("usb pll active after reset");
   sleep_entry_a: assert property (cpu_clock_en_o && sleep_req_i |=> !cpu_clock_en_o)
      else $error("core clock kept after sleep request");
   sleep_wake_a: assert property (!cpu_clock_en_o && periph_clock_en_o &&
      (irq_i & irq_mask_i) != 32'h0 |-> ##[1:2] cpu_clock_en_o) else $error("no wake on irq");
   clocks_stop_a: assert property (!periph_clock_en_o |-> periph_gate_o == 8'h00 &&
      usb_div_zero_o && pin_hold_o && !internal_rc_osc_out_en_o) else $error("clock leaks");
   deep_flash_a: assert property (pin_hold_o && internal_rc_osc_pwr_o |-> flash_pwr_o)
      else $error("flash unpowered while rc powered");
   pdown_cut_a: assert property ($fell(internal_rc_osc_pwr_o) && !chip_pwr_off_o
      |-> !flash_pwr_o && !flash_ready_o) else $error("flash left on in power-down");
   dpd_source_a: assert property ($rose(chip_pwr_off_o)
      |-> $past(rtc_dpd_req_i) || $past(rtc_dpd_req_i, 2)) else $error("dpd without rtc");
   dpd_hold_a: assert property (chip_pwr_off_o && !rtc_alarm_i |=> chip_pwr_off_o)
      else $error("deep power-down left without alarm");
   wake_pulse_a: assert property ($rose(cpu_clock_en_o) |-> wake_o ##1 !wake_o)
      else $error("wake pulse wrong");
   sleep_seen_c: cover property (!cpu_clock_en_o && periph_clock_en_o);
   pdown_seen_c: cover property (!flash_pwr_o && !chip_pwr_off_o);
   dpd_seen_c: cover property (chip_pwr_off_o);
endmodule
////////////////////////////////////////////////////////////
bind lpms_sequencer lpms_props u_lpms_props (.clk_i, .rst_i, .sleep_req_i, .rtc_dpd_req_i,
   .rtc_alarm_i, .irq_i, .irq_mask_i, .cpu_clock_en_o, .periph_clock_en_o, .periph_gate_o,
   .usb_div_zero_o, .usb_pll_pwr_o, .usb_pll_connect_o, .internal_rc_osc_pwr_o,
   .internal_rc_osc_out_en_o, .flash_pwr_o, .flash_ready_o, .pin_hold_o, .chip_pwr_off_o,
   .wake_o);

// File: bench/lpms_core_model.sv
`timescale 1ns/1ps
module lpms_core_model
   import lpms_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wfi_i,
   input  wire logic [LPMS_NIRQ-1:0] irq_en_i,
   input  wire logic [LPMS_NIRQ-1:0] prio_ok_i,
   input  wire logic                 cpu_clock_en_i,
   output logic                      sleep_req_o,
   output logic [LPMS_NIRQ-1:0]      irq_mask_o
);
   // A stopped core cannot act, so the mask freezes and the request drops while asleep.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sleep_req_o <= 1'b0;
         irq_mask_o  <= 32'h0;
      end else begin
         sleep_req_o <= wfi_i & cpu_clock_en_i;
         if (cpu_clock_en_i) begin
            irq_mask_o <= irq_en_i & prio_ok_i;
         end
      end
   end
endmodule

// File: bench/low_power_mode_sequencer_tb.sv
`timescale 1ns/1ps
module low_power_mode_sequencer_tb;
   import lpms_pkg::*;
   logic                      clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0;
   logic                      wb_stb_i = 1'b0, wfi = 1'b0, rtc_dpd_req_i = 1'b0;
   logic                      rtc_alarm_i = 1'b0, rc_tick_i = 1'b0;
   logic [7:0]                wb_adr_i = 8'h00;
   logic [3:0]                wb_sel_i = 4'hf;
   logic [4:0]                tick_cnt = 5'h00;
   logic [31:0]               wb_dat_i = 32'h0, g = 32'h0, q, wb_dat_o;
   logic [LPMS_NIRQ-1:0]      irq_i = 32'h0, irq_en = 32'h0, prio_ok = 32'h0, irq_mask_i;
   logic [LPMS_NPERIPH-1:0]   periph_gate_o;
   logic [LPMS_NPERIPH*4-1:0] periph_div_o;
   logic [7:0]                cpu_div_o;
   logic [1:0]                clk_src_o;
   logic                      wb_ack_o, sleep_req_i, cpu_clock_en_o, periph_clock_en_o;
   logic                      main_osc_en_o, main_pll_en_o, main_pll_connect_o, wake_o;
   logic                      internal_rc_osc_pwr_o, internal_rc_osc_out_en_o, usb_pll_pwr_o;
   logic                      usb_pll_connect_o, usb_div_zero_o, flash_pwr_o, flash_ready_o;
   logic                      pin_hold_o, chip_pwr_off_o;
   int                        bad_count = 0, n_checks = 0, n = 0, t = 0, ticks = 0;
   lpms_sequencer u_lpms_sequencer (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
      .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .sleep_req_i, .irq_mask_i, .irq_i,
      .rtc_dpd_req_i, .rtc_alarm_i, .rc_tick_i, .cpu_clock_en_o, .periph_clock_en_o,
      .periph_gate_o, .periph_div_o, .cpu_div_o, .clk_src_o, .main_osc_en_o, .main_pll_en_o,
      .main_pll_connect_o, .internal_rc_osc_pwr_o, .internal_rc_osc_out_en_o, .usb_pll_pwr_o,
      .usb_pll_connect_o, .usb_div_zero_o, .flash_pwr_o, .flash_ready_o, .pin_hold_o,
      .chip_pwr_off_o, .wake_o);
   lpms_core_model u_lpms_core_model (.clk_i, .rst_i, .wfi_i(wfi), .irq_en_i(irq_en),
      .prio_ok_i(prio_ok), .cpu_clock_en_i(cpu_clock_en_o), .sleep_req_o(sleep_req_i),
      .irq_mask_o(irq_mask_i));
   ////////////////////////////////////////////////////////////
   always #4 clk_i = ~clk_i;
   // One RC tick every 32 clocks, close to the real oscillator ratio.
   always @(posedge clk_i) begin
      tick_cnt  <= tick_cnt + 5'h01;
      rc_tick_i <= (tick_cnt == 5'h1f);
      ticks     <= ticks + int'(rc_tick_i);
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_we_i  <= we;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      for (k = 0; k < 16 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (k == 16) begin
         chk("ack", 32'h1, 32'h0);
         final_report();
      end
   endtask
   task automatic go(input logic [1:0] m, input logic wr);
      if (wr) wb(1'b1, LPMS_ADDR_MODE, {30'h0, m});
      @(posedge clk_i);
      wfi <= 1'b1;
      @(posedge clk_i);
      wfi <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   // A hung wake must not stall the run, so every wait is bounded.
   task automatic wait_run();
      for (n = 0; n < 9000 && cpu_clock_en_o !== 1'b1; n++) @(posedge clk_i);
      if (n == 9000) begin
         chk("wake", 32'h1, 32'h0);
         final_report();
      end
   endtask
   function automatic int near(input int lo);
      return (n >= lo && n <= lo + 3) ? lo : n;
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(58));
      repeat (3) @(posedge clk_i);
      chk("usb pll", 32'h0, {usb_pll_pwr_o, usb_pll_connect_o});
      chk("clk src", LPMS_SRC_RC, clk_src_o);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         g = $urandom();
         wb(1'b1, LPMS_ADDR_PCLKEN, g);
         wb(1'b1, LPMS_ADDR_PCLKDIV, ~g);
         wb(1'b1, LPMS_ADDR_CPUDIV, {24'h0, g[15:8] | 8'h01});
         wb(1'b0, LPMS_ADDR_PCLKEN, 32'h0);
         chk("gate", {g[7:0], g[7:0]}, {q[7:0], periph_gate_o});
         chk("dividers", ~g, periph_div_o);
         chk("cpu div", g[15:8] | 8'h01, cpu_div_o);
         wb(1'b1, 8'h20 + {2'b00, g[3:0], 2'b00}, g);
         wb(1'b0, 8'h20 + {2'b00, g[3:0], 2'b00}, 32'h0);
         chk("unmapped", 32'h0, q);
      end
      $display("register test done");
      irq_en  <= $urandom() | 32'h8;
      prio_ok <= ($urandom() | 32'h8) & ~32'h20;
      go(LPMS_MODE_SLEEP, 1'b0);
      chk("sleep clk", {g[7:0], 2'b01}, {periph_gate_o, cpu_clock_en_o, periph_clock_en_o});
      irq_i <= 32'h20;
      repeat (6) @(posedge clk_i);
      chk("unmasked", 32'h0, cpu_clock_en_o);
      irq_i <= 32'h28;
      wait_run();
      chk("sleep wake", 32'h1, n <= 3);
      irq_i <= 32'h0;
      wb(1'b0, LPMS_ADDR_WAKEMASK, 32'h0);
      chk("wake mask", irq_en & prio_ok, q);
      $display("sleep test done");
      go(LPMS_MODE_DEEP, 1'b1);
      chk("deep div", 32'h0, cpu_div_o);
      chk("deep rc", 32'h2, {internal_rc_osc_pwr_o, internal_rc_osc_out_en_o});
      chk("deep hold", 32'h7, {flash_pwr_o, pin_hold_o, usb_div_zero_o});
      irq_i <= 32'h8;
      wait_run();
      chk("deep rc wait", 4 * LPMS_RC_RATIO, near(4 * LPMS_RC_RATIO));
      irq_i <= 32'h0;
      wb(1'b1, LPMS_ADDR_CLKSRC, LPMS_SRC_MAIN);
      wb(1'b1, LPMS_ADDR_USBPLL, 32'h3);
      repeat (2) @(posedge clk_i);
      chk("usb pll on", {4'b1110, LPMS_SRC_MAIN}, {usb_pll_pwr_o, usb_pll_connect_o,
         main_osc_en_o, main_pll_en_o, clk_src_o});
      go(LPMS_MODE_DEEP, 1'b1);
      chk("deep off", 32'h0, {usb_pll_pwr_o, main_osc_en_o, main_pll_connect_o});
      irq_i <= 32'h8;
      wait_run();
      chk("deep main wait", LPMS_MAIN_WAKE_CYC, near(LPMS_MAIN_WAKE_CYC));
      irq_i <= 32'h0;
      wb(1'b1, LPMS_ADDR_CPUDIV, {24'h0, g[23:16]});
      $display("deep-sleep test done");
      go(LPMS_MODE_PDOWN, 1'b1);
      chk("pdown pwr", 32'h0, {internal_rc_osc_pwr_o, flash_pwr_o, flash_ready_o});
      rtc_alarm_i <= 1'b1;
      t = ticks;
      @(posedge clk_i);
      rtc_alarm_i <= 1'b0;
      wait_run();
      chk("pdown wait", LPMS_RC_START_CYC + 128, near(LPMS_RC_START_CYC + 128));
      chk("flash blocked", 32'h0, flash_ready_o);
      for (n = 0; n < 20000 && flash_ready_o !== 1'b1; n++) @(posedge clk_i);
      if (n == 20000) begin
         chk("flash wait", 32'h1, 32'h0);
         final_report();
      end
      chk("flash ticks", 32'h1, ticks - t >= LPMS_FLASH_RC_CYC && ticks - t <= 640);
      $display("power-down test done");
      rtc_dpd_req_i <= 1'b1;
      @(posedge clk_i);
      rtc_dpd_req_i <= 1'b0;
      irq_i <= 32'h8;
      repeat (20) @(posedge clk_i);
      chk("dpd held", 32'h1, chip_pwr_off_o);
      irq_i <= 32'h0;
      rtc_alarm_i <= 1'b1;
      @(posedge clk_i);
      rtc_alarm_i <= 1'b0;
      wait_run();
      chk("dpd left", 32'h0, chip_pwr_off_o);
      $display("deep power-down test done");
      wb(1'b1, LPMS_ADDR_MODE, 32'h3);
      wb(1'b0, LPMS_ADDR_MODE, 32'h0);
      chk("mode keep", LPMS_MODE_PDOWN, q);
      wb(1'b1, LPMS_ADDR_CLKSRC, LPMS_SRC_PLL);
      repeat (2) @(posedge clk_i);
      chk("pll src", {3'b111, LPMS_SRC_PLL}, {main_osc_en_o, main_pll_en_o,
         main_pll_connect_o, clk_src_o});
      $display("source test done");
      final_report();
   end
endmodule
